// File: src/tbg_defs.vh
// constants for the trigger blocking gate
// What this block does
// - without blocking setup, every trigger passes
// - blocker edges ignored while blocker unarmed, except by the pulse count
// - reception on, blocker unreleased: withhold triggers
// - release-once: block until first event, then pass
// - blocking source selectable: panel trigger, sync or one of two other inputs
// - window-open: edge starts timed pass window
// - window-closed: reject inside window, pass outside
// - gate: accept only while blocking signal high (low when falling polarity is set)
// - triggers outside acceptance are discarded silently
// - accepted trigger yields full record with pretrigger
// - accepted record runs full length past window
// - window-open: every trigger in the window is accepted
// - each blocking period frames a trigger group
// - release event aligns timestamp reset pulse
// - count blocking source pulses, readable by software
`ifndef TBG_DEFS_VH
`define TBG_DEFS_VH
`define TBG_ADDR_CTRL     12'h000
`define TBG_ADDR_WINLEN   12'h004
`define TBG_ADDR_STATUS   12'h008
`define TBG_ADDR_COUNT    12'h00c
`define TBG_ADDR_GROUP    12'h010
`define TBG_CTRL_BLK_EN   0
`define TBG_CTRL_RX_EN    1
`define TBG_CTRL_REL_EN   2
`define TBG_CTRL_MODE_LO  3
`define TBG_CTRL_MODE_HI  4
`define TBG_CTRL_SRC_LO   5
`define TBG_CTRL_SRC_HI   6
`define TBG_CTRL_FALL     7
`define TBG_CTRL_TSR_EN   8
`define TBG_CTRL_RST      9'h000
`define TBG_WINLEN_RST    32'h00000100
`define TBG_MODE_ONCE     2'h0
`define TBG_MODE_WOPEN    2'h1
`define TBG_MODE_WCLOSE   2'h2
`define TBG_MODE_GATE     2'h3
`endif

// File: src/tbg_src_edge.v
// source selection and edge detection for the blocking signal
`timescale 1ns/1ps
module tbg_src_edge (
   input  wire       pclk,
   input  wire       presetn,
   input  wire [3:0] src_in,
   input  wire [1:0] src_sel,
   input  wire       fall_edge,
   output reg        level_q,
   output reg        edge_q
);
   reg  [3:0] prev_q;
   wire       cur  = src_in[src_sel];
   wire       last = prev_q[src_sel];
   // every line keeps its own history, so a change of selection or of
   // polarity never turns two different levels into a false edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q  <= 4'h0;
         level_q <= 1'b0;
         edge_q  <= 1'b0;
      end else begin
         prev_q  <= src_in;
         level_q <= cur ^ fall_edge;
         edge_q  <= fall_edge ? (last & ~cur) : (cur & ~last);
      end
   end
endmodule // tbg_src_edge

// File: src/tbg_win_timer.v
// window timer, restarted on every qualifying edge in the window modes, unless the length is zero
`timescale 1ns/1ps
module tbg_win_timer (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        start,
   input  wire [31:0] win_len,
   output reg         open_q
);
   reg [31:0] cnt_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= 32'h00000000;
         open_q <= 1'b0;
      end else if (start && win_len != 32'h00000000) begin
         cnt_q  <= win_len - 32'h00000001;
         open_q <= 1'b1;
      end else if (cnt_q != 32'h00000000) begin
         cnt_q <= cnt_q - 32'h00000001;
      end else begin
         open_q <= 1'b0;
      end
   end
endmodule // tbg_win_timer

// File: src/tbg_gate.v
// trigger blocking gate top with apb register file
`timescale 1ns/1ps
`include "tbg_defs.vh"
module tbg_gate (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        front_panel_event_input_in,
   input  wire        front_panel_event_input,
   input  wire        sync_in,
   input  wire [1:0]  other_src_in,
   output reg         front_panel_event_input_out,
   output reg         ts_reset
);
   // ----------------------------------------------------------------
   // registers and nets
   // ----------------------------------------------------------------
   localparam HIT_CTRL   = 0;
   localparam HIT_WINLEN = 1;
   localparam HIT_STATUS = 2;
   localparam HIT_COUNT  = 3;
   localparam HIT_GROUP  = 4;
   localparam N_REGS     = 5;

   reg  [8:0]  ctrl_q;
   reg  [8:0]  ctrl_d;
   reg  [31:0] winlen_q;
   reg  [31:0] winlen_d;
   reg  [31:0] count_q;
   reg  [31:0] count_d;
   reg  [31:0] group_q;
   reg  [31:0] group_d;
   reg         released_q;
   reg         released_d;
   reg         once_done_q;
   reg         once_done_d;
   reg  [31:0] prdata_d;
   reg         pready_d;
   reg         pslverr_d;
   reg         front_panel_event_input_out_d;
   reg         ts_reset_d;
   reg         accept;
   reg  [31:0] rd_d;
   wire        level;
   wire        edge_ev;
   wire        win_open;
   wire        win_start;
   wire [1:0]  mode;
   wire [1:0]  src_sel;
   wire        blk_en;
   wire        rx_en;
   wire        rel_en;
   wire        fall_sel;
   wire        tsr_en;
   wire        armed;
   wire        qual_ev;
   wire        setup_ph;
   wire        wr_acc;
   wire        rd_set;
   wire [4:0]  hit;
   wire        mapped;

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   function is_addr;
      input [11:0] a;
      input [11:0] ref_a;
      begin
         is_addr = (a == ref_a);
      end
   endfunction

   function [11:0] reg_addr;
      input integer idx;
      begin
         case (idx)
            HIT_CTRL:   reg_addr = `TBG_ADDR_CTRL;
            HIT_WINLEN: reg_addr = `TBG_ADDR_WINLEN;
            HIT_STATUS: reg_addr = `TBG_ADDR_STATUS;
            HIT_COUNT:  reg_addr = `TBG_ADDR_COUNT;
            HIT_GROUP:  reg_addr = `TBG_ADDR_GROUP;
            default:    reg_addr = 12'hfff;
         endcase
      end
   endfunction

   function is_window_mode;
      input [1:0] m;
      begin
         is_window_mode = (m == `TBG_MODE_WOPEN) || (m == `TBG_MODE_WCLOSE);
      end
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < N_REGS; gi = gi + 1) begin : g_hit
         assign hit[gi] = is_addr(paddr, reg_addr(gi));
      end
   endgenerate

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   assign mode     = ctrl_q[`TBG_CTRL_MODE_HI:`TBG_CTRL_MODE_LO];
   assign src_sel  = ctrl_q[`TBG_CTRL_SRC_HI:`TBG_CTRL_SRC_LO];
   assign blk_en   = ctrl_q[`TBG_CTRL_BLK_EN];
   assign rx_en    = ctrl_q[`TBG_CTRL_RX_EN];
   assign rel_en   = ctrl_q[`TBG_CTRL_REL_EN];
   assign fall_sel = ctrl_q[`TBG_CTRL_FALL];
   assign tsr_en   = ctrl_q[`TBG_CTRL_TSR_EN];

   // ----------------------------------------------------------------
   // apb phases
   // ----------------------------------------------------------------
   assign setup_ph = psel & ~penable;
   assign wr_acc   = psel & penable & pwrite & pready;
   assign rd_set   = setup_ph & ~pwrite;
   assign mapped   = |hit;

   // ----------------------------------------------------------------
   // blocking source and window
   // ----------------------------------------------------------------
   tbg_src_edge u_src (
      .pclk      (pclk),
      .presetn   (presetn),
      .src_in    ({other_src_in, sync_in, front_panel_event_input}),
      .src_sel   (src_sel),
      .fall_edge (fall_sel),
      .level_q   (level),
      .edge_q    (edge_ev)
   );

   // edges only qualify once the blocker is armed and trigger reception is on
   assign armed     = blk_en & rx_en & rel_en;
   assign qual_ev   = armed & edge_ev;
   assign win_start = qual_ev & is_window_mode(mode);

   tbg_win_timer u_win (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (win_start),
      .win_len (winlen_q),
      .open_q  (win_open)
   );

   // ----------------------------------------------------------------
   // acceptance decision
   // ----------------------------------------------------------------
   always @* begin
      accept = 1'b0;
      if (!blk_en) begin
         accept = 1'b1;
      end else if (!rx_en || !rel_en) begin
         accept = 1'b0;
      end else begin
         case (mode)
            `TBG_MODE_ONCE:   accept = released_q;
            `TBG_MODE_WOPEN:  accept = win_open;
            `TBG_MODE_WCLOSE: accept = ~win_open;
            `TBG_MODE_GATE:   accept = level;
            default:          accept = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // trigger path
   // ----------------------------------------------------------------
   // a passed trigger is a single pulse; the acquisition engine owns record
   // length and pretrigger, so closing the window never cuts a record short
   always @* begin
      front_panel_event_input_out_d = front_panel_event_input_in & accept;
      ts_reset_d = tsr_en & qual_ev & (mode == `TBG_MODE_ONCE) & ~once_done_q;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         front_panel_event_input_out <= 1'b0;
         ts_reset <= 1'b0;
      end else begin
         front_panel_event_input_out <= front_panel_event_input_out_d;
         ts_reset <= ts_reset_d;
      end
   end

   // ----------------------------------------------------------------
   // release once
   // ----------------------------------------------------------------
   always @* begin
      released_d  = released_q;
      once_done_d = once_done_q;
      if (!armed) begin
         released_d  = 1'b0;
         once_done_d = 1'b0;
      end else if (qual_ev && mode == `TBG_MODE_ONCE) begin
         released_d  = 1'b1;
         once_done_d = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         released_q  <= 1'b0;
         once_done_q <= 1'b0;
      end else begin
         released_q  <= released_d;
         once_done_q <= once_done_d;
      end
   end

   // ----------------------------------------------------------------
   // pulse and group counters
   // ----------------------------------------------------------------
   // the count keeps running even with blocking off, so activity shows;
   // an edge beats a software clear in the same cycle
   always @* begin
      count_d = count_q;
      if (edge_ev) begin
         count_d = count_q + 32'h00000001;
      end else if (wr_acc && hit[HIT_COUNT]) begin
         count_d = 32'h00000000;
      end
   end

   always @* begin
      group_d = group_q;
      if (qual_ev) begin
         group_d = group_q + 32'h00000001;
      end else if (wr_acc && hit[HIT_GROUP]) begin
         group_d = 32'h00000000;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= 32'h00000000;
         group_q <= 32'h00000000;
      end else begin
         count_q <= count_d;
         group_q <= group_d;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always @* begin
      ctrl_d   = ctrl_q;
      winlen_d = winlen_q;
      if (wr_acc && hit[HIT_CTRL]) begin
         ctrl_d = pwdata[8:0];
      end
      if (wr_acc && hit[HIT_WINLEN]) begin
         winlen_d = pwdata;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= `TBG_CTRL_RST;
         winlen_q <= `TBG_WINLEN_RST;
      end else begin
         ctrl_q   <= ctrl_d;
         winlen_q <= winlen_d;
      end
   end

   // ----------------------------------------------------------------
   // apb slave: no wait states, fixed
   // ----------------------------------------------------------------
   always @* begin
      rd_d = 32'h00000000;
      case (paddr)
         `TBG_ADDR_CTRL:   rd_d = {23'h000000, ctrl_q};
         `TBG_ADDR_WINLEN: rd_d = winlen_q;
         `TBG_ADDR_STATUS: rd_d = {28'h0000000, accept, level, win_open, released_q};
         `TBG_ADDR_COUNT:  rd_d = count_q;
         `TBG_ADDR_GROUP:  rd_d = group_q;
         default:          rd_d = 32'h00000000;
      endcase
   end

   // read data is caught at setup so it stands through the access cycle
   always @* begin
      pready_d  = setup_ph;
      pslverr_d = setup_ph & ~mapped;
      prdata_d  = prdata;
      if (rd_set) begin
         prdata_d = rd_d;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= prdata_d;
         pready  <= pready_d;
         pslverr <= pslverr_d;
      end
   end
endmodule // tbg_gate

// File: tb/tbg_sync_src.sv
// partner model: blocking source pulse generator
`timescale 1ns/1ps
module tbg_sync_src (
   input  wire       pclk,
   input  wire       fire,
   input  wire [1:0] sel,
   input  wire [7:0] len,
   output reg  [3:0] src_q
);
   reg [7:0] cnt_q;
   initial begin
      src_q = 4'h0;
      cnt_q = 8'h00;
   end
   // unselected lines idle low, one line pulses per request
   always @(posedge pclk) begin
      if (fire) begin
         cnt_q <= len;
         src_q <= 4'h1 << sel;
      end else if (cnt_q > 8'h01) begin
         cnt_q <= cnt_q - 8'h01;
      end else begin
         cnt_q <= 8'h00;
         src_q <= 4'h0;
      end
   end
endmodule // tbg_sync_src

// File: tb/tbg_gate_asserts.sv
// checker on the trigger blocking gate ports
`timescale 1ns/1ps
module tbg_gate_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        front_panel_event_input_in,
   input wire        front_panel_event_input,
   input wire        sync_in,
   input wire [1:0]  other_src_in,
   input wire        front_panel_event_input_out,
   input wire        ts_reset
);
   // ----
   // shadow of the control word, taken at the commit edge
   // ----
   reg  [8:0] ctrl_q;
   wire       armed = &ctrl_q[2:0];
   wire [3:0] srcs  = {other_src_in, sync_in, front_panel_event_input};
   wire       lvl   = srcs[ctrl_q[6:5]] ^ ctrl_q[7];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_q <= 9'h000;
      else if (psel && penable && pready && pwrite && paddr == 12'h000) ctrl_q <= pwdata[8:0];
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_after: assert property (psel && !penable |=> pready) else $error("no pready after setup");
   chk_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
   chk_ready_once: assert property (pready |=> !pready) else $error("pready held");
   chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   chk_front_panel_event_input_idle: assert property (!front_panel_event_input_in |=> !front_panel_event_input_out) else $error("trigger from nothing");
   chk_pass_free: assert property (!ctrl_q[0] && front_panel_event_input_in |=> front_panel_event_input_out) else $error("free trigger lost");
   chk_hold_unarmed: assert property (ctrl_q[0] && !armed && front_panel_event_input_in |=> !front_panel_event_input_out)
      else $error("trigger passed unarmed");
   chk_gate_shut: assert property (armed && ctrl_q[4:3] == 2'h3 && front_panel_event_input_in && !lvl && !$past(lvl)
      && !$past(lvl, 2) |=> !front_panel_event_input_out) else $error("trigger passed closed gate");
endmodule // tbg_gate_chk

// File: tb/tb_tbg_gate.sv
// testbench for the trigger blocking gate
`timescale 1ns/1ps
`include "tbg_defs.vh"
module tb_tbg_gate;
   reg         pclk, presetn, psel, penable, pwrite, front_panel_event_input_in, fire, er;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [1:0]  sel;
   reg  [7:0]  len;
   wire [31:0] prdata;
   wire        pready, pslverr, front_panel_event_input_out, ts_reset;
   wire [3:0]  src;
   integer     fail_count, n_tests, nf, seed, m, s, w;
   integer     n_out = 0;
   integer     n_ts = 0;
   tbg_gate i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .front_panel_event_input_in(front_panel_event_input_in),
      .front_panel_event_input(src[0]), .sync_in(src[1]), .other_src_in(src[3:2]), .front_panel_event_input_out(front_panel_event_input_out),
      .ts_reset(ts_reset));
   tbg_sync_src i_src (.pclk(pclk), .fire(fire), .sel(sel), .len(len), .src_q(src));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (front_panel_event_input_out === 1'b1) n_out <= n_out + 1;
      if (ts_reset === 1'b1) n_ts <= n_ts + 1;
   end
   // open window mode passes inside, closed window mode passes outside
   function automatic exp_pass(input integer md, input integer inw);
      exp_pass = (md == 1) ? (inw != 0) : (inw == 0);
   endfunction
   task tally_and_finish;
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task cmp(input [31:0] e, input [31:0] g, input string nm);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("Error %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      integer k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 8);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         tally_and_finish;
      end
   endtask
   task shot(input e);
      integer b;
      b = n_out;
      @(posedge pclk) front_panel_event_input_in <= 1'b1;
      @(posedge pclk) front_panel_event_input_in <= 1'b0;
      repeat (3) @(posedge pclk);
      cmp(e, n_out - b, "front_panel_event_input_out");
   endtask
   task burst(input [1:0] sl, input [7:0] ln);
      @(posedge pclk);
      fire <= 1'b1;
      sel <= sl;
      len <= ln;
      @(posedge pclk) fire <= 1'b0;
      nf++;
      repeat (5) @(posedge pclk);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, front_panel_event_input_in, fire, sel, len, rd, er} = 0;
      {fail_count, n_tests, nf} = 0;
      seed = 32'h516a565f;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `TBG_ADDR_CTRL, 0);
      cmp(`TBG_CTRL_RST, rd, "ctrl");
      apb(0, `TBG_ADDR_WINLEN, 0);
      cmp(`TBG_WINLEN_RST, rd, "winlen");
      apb(1, 12'h014, 32'hffffffff);
      cmp(1, er, "pslverr");
      apb(0, 12'h014, 0);
      cmp(0, rd, "unmapped");
      apb(1, `TBG_ADDR_COUNT, 0);
      for (m = 0; m < 4; m++) begin
         repeat ($random(seed) & 7) @(posedge pclk);
         shot(1);
      end
      apb(1, `TBG_ADDR_CTRL, 3);
      shot(0);
      burst(0, 4);
      shot(0);
      apb(1, `TBG_ADDR_CTRL, 32'h127);
      shot(0);
      burst(1, 4);
      cmp(1, n_ts, "ts_reset");
      shot(1);
      for (m = 1; m < 3; m++) for (s = 0; s < 4; s++) begin
         w = 24 + ($random(seed) & 7);
         apb(1, `TBG_ADDR_WINLEN, w);
         apb(1, `TBG_ADDR_CTRL, 7 | m << 3 | s << 5);
         burst(s, 2);
         shot(exp_pass(m, 1));
         shot(exp_pass(m, 1));
         repeat (w) @(posedge pclk);
         shot(exp_pass(m, 0));
      end
      apb(1, `TBG_ADDR_CTRL, 32'h03f);
      burst(1, 20);
      shot(1);
      repeat (20) @(posedge pclk);
      shot(0);
      // inverted polarity: the idle-low line now holds the gate open
      apb(1, `TBG_ADDR_CTRL, 32'h0bf);
      shot(1);
      burst(1, 20);
      shot(0);
      repeat (20) @(posedge pclk);
      shot(1);
      apb(0, `TBG_ADDR_COUNT, 0);
      cmp(nf, rd, "count");
      apb(0, `TBG_ADDR_GROUP, 0);
      cmp(nf - 1, rd, "group");
      tally_and_finish;
   end
endmodule // tb_tbg_gate
bind tbg_gate tbg_gate_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .front_panel_event_input_in(front_panel_event_input_in), .front_panel_event_input(front_panel_event_input), .sync_in(sync_in),
   .other_src_in(other_src_in), .front_panel_event_input_out(front_panel_event_input_out), .ts_reset(ts_reset));
